// ==== core/plg_pkg.sv ====
package plg_pkg;

  // ==========================================================================
  // Widths and sizes
  localparam int PIX_IN_W   = 10;
  localparam int PIX_OUT_W  = 8;
  localparam int WIDE_W     = 12;
  localparam int ENTRY_W    = 10;
  localparam int USED_DEPTH = 512;
  localparam int ADDR_W     = 8;
  localparam int GAMMA_W    = 12;
  localparam int LOG_W      = 15;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SELECT = 8'h04;
  localparam logic [7:0] OFS_INDEX  = 8'h08;
  localparam logic [7:0] OFS_VALUE  = 8'h0C;
  localparam logic [7:0] OFS_GAMMA  = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_IGNORE = 8'h18;

  // Control field positions
  localparam int CTRL_MAP_EN = 0;
  localparam int CTRL_GAM_EN = 1;
  localparam int CTRL_WIDE   = 2;

  // ==========================================================================
  // Values and reset values
  localparam logic             SEL_LUMINANCE = 1'h0;
  localparam logic [9:0]       TOP_CODE      = 10'h3FF;
  localparam logic [8:0]       TOP_PAIR      = 9'h1FF;
  localparam logic [11:0]      GAMMA_ONE     = 12'h400;
  localparam logic [11:0]      GAMMA_RESET   = 12'h400;
  localparam logic [11:0]      FS_NARROW     = 12'h0FF;
  localparam logic [11:0]      FS_WIDE       = 12'hFFF;
  localparam logic [12:0]      MANT_ONE      = 13'h1000;
  localparam logic [15:0]      COUNT_MAX     = 16'hFFFF;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic                valid;
    logic [PIX_IN_W-1:0] data;
  } plg_pix_in_s;

  typedef struct packed {
    logic              valid;
    logic [WIDE_W-1:0] data;
  } plg_samp_s;

  typedef struct packed {
    logic                 valid;
    logic [PIX_OUT_W-1:0] data;
    logic [WIDE_W-1:0]    wide;
  } plg_pix_out_s;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
  } plg_reg_req_s;

  // ==========================================================================
  // Module state
  typedef struct packed {
    logic                   map_en;
    logic                   gam_en;
    logic                   wide;
    logic                   sel;
    logic [9:0]             index;
    logic [GAMMA_W-1:0]     gamma;
    logic [15:0]            pix_count;
    logic [15:0]            ignore_count;
    logic [7:0]             last_pix;
    logic [31:0]            rdata;
    logic                   s1_v;
    logic                   s1_map;
    logic [9:0]             s1_raw;
    logic [ENTRY_W-1:0]     s1_lo;
    logic [ENTRY_W-1:0]     s1_hi;
    logic                   s2_v;
    logic [9:0]             s2_m10;
    logic [USED_DEPTH-1:0][ENTRY_W-1:0] table_mem;
  } plg_main_state_s;

  typedef struct packed {
    logic               v1;
    logic               w1;
    logic               pass1;
    logic [11:0]        x1;
    logic [LOG_W-1:0]   l1;
    logic [GAMMA_W-1:0] g1;
    logic               v2;
    logic               w2;
    logic               pass2;
    logic [11:0]        x2;
    logic [16:0]        m2;
    plg_pix_out_s       out;
  } plg_gam_state_s;

  // Leading-one log2 with a linear fraction: {int[3:0], frac[10:0]}
  function automatic logic [LOG_W-1:0] plg_log2fx(input logic [11:0] x);
    logic [3:0]  k;
    logic [11:0] norm;
    k = 4'h0;
    for (int i = 0; i < 12; i++) begin
      if (x[i]) begin
        k = 4'(i);
      end
    end
    norm = x << (4'hB - k);
    return {k, norm[10:0]};
  endfunction : plg_log2fx

endpackage : plg_pkg

// ==== core/plg_gamma.sv ====
`timescale 1ns/1ns
module plg_gamma
  import plg_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // Settings
  input  wire logic               gamma_en,
  input  wire logic               wide,
  input  wire logic [GAMMA_W-1:0] factor,
  // Stream
  input  wire plg_samp_s          samp_in,
  output plg_pix_out_s            pix_out
);

  plg_gam_state_s st;
  plg_gam_state_s next_st;

  logic [11:0] fs_in;
  logic [11:0] fs2;
  logic [11:0] x_in;
  logic [14:0] lx;
  logic [14:0] lf;
  logic [26:0] prod;
  logic [12:0] mant;
  logic [24:0] scaled;
  logic [12:0] shifted;
  logic [11:0] y;

  // ==========================================================================
  // Stage 1 log, stage 2 exponent product, stage 3 exp2 and format
  always_comb begin
    next_st = st;
    fs_in = wide ? FS_WIDE : FS_NARROW;
    x_in = (samp_in.data > fs_in) ? fs_in : samp_in.data;
    lx = plg_log2fx(x_in);
    lf = plg_log2fx(fs_in);
    next_st.v1 = samp_in.valid;
    next_st.w1 = wide;
    next_st.x1 = x_in;
    next_st.g1 = factor;
    // Bypass, unit factor and both end points skip the approximation
    next_st.pass1 = !gamma_en || (factor == GAMMA_ONE)
                    || (x_in == 12'h000) || (x_in == fs_in);
    next_st.l1 = (lf > lx) ? 15'(lf - lx) : 15'h0000;
    prod = {12'h000, st.l1} * {15'h0000, st.g1};
    next_st.v2 = st.v1;
    next_st.w2 = st.w1;
    next_st.x2 = st.x1;
    next_st.pass2 = st.pass1;
    next_st.m2 = prod[26:10];
    fs2 = st.w2 ? FS_WIDE : FS_NARROW;
    mant = MANT_ONE - {2'h0, st.m2[10:0]};
    scaled = {13'h0000, fs2} * {12'h000, mant};
    shifted = scaled[24:12] >> st.m2[16:11];
    if (st.pass2) begin
      y = st.x2;
    end else if (shifted > {1'h0, fs2}) begin
      y = fs2;
    end else begin
      y = shifted[11:0];
    end
    next_st.out.valid = st.v2;
    next_st.out.data = st.w2 ? y[11:4] : y[7:0];
    next_st.out.wide = st.w2 ? y : {y[7:0], y[7:4]};
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pix_out = st.out;

endmodule : plg_gamma

// ==== core/plg_top.sv ====
`timescale 1ns/1ns
module plg_top
  import plg_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  // Sensor samples in
  input  wire plg_pix_in_s       pix_in,
  // Pixels out
  output plg_pix_out_s           pix_out
);

  plg_main_state_s st;
  plg_main_state_s next_st;

  plg_samp_s    gam_in;
  plg_pix_out_s gam_out;

  logic [8:0]  in_pair;
  logic [8:0]  idx_pair;
  logic [10:0] pair_sum;
  logic        entry_ok;

  // ==========================================================================
  // Register access, table storage and the mapping pipeline
  always_comb begin
    next_st = st;
    next_st.rdata = 32'h0000_0000;
    idx_pair = st.index[9:1];
    // Only even addresses of the luminance table hold storage
    entry_ok = !st.index[0] && (st.sel == SEL_LUMINANCE);

    // ------------------------------------------------------------------------
    // Writes
    if (reg_wr) begin
      case (reg_addr)
        OFS_CTRL: begin
          next_st.map_en = reg_wdata[CTRL_MAP_EN];
          next_st.gam_en = reg_wdata[CTRL_GAM_EN];
          next_st.wide = reg_wdata[CTRL_WIDE];
        end
        OFS_SELECT: begin
          next_st.sel = reg_wdata[0];
        end
        OFS_INDEX: begin
          next_st.index = reg_wdata[9:0];
        end
        OFS_VALUE: begin
          if (entry_ok) begin
            next_st.table_mem[idx_pair] = reg_wdata[ENTRY_W-1:0];
          end else if (st.ignore_count != COUNT_MAX) begin
            next_st.ignore_count = 16'(st.ignore_count + 16'h0001);
          end
        end
        OFS_GAMMA: begin
          next_st.gamma = reg_wdata[GAMMA_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // ------------------------------------------------------------------------
    // Reads, answered in the following cycle
    if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL: begin
          next_st.rdata[CTRL_MAP_EN] = st.map_en;
          next_st.rdata[CTRL_GAM_EN] = st.gam_en;
          next_st.rdata[CTRL_WIDE] = st.wide;
        end
        OFS_SELECT: begin
          next_st.rdata[0] = st.sel;
        end
        OFS_INDEX: begin
          next_st.rdata[9:0] = st.index;
        end
        OFS_VALUE: begin
          if (entry_ok) begin
            next_st.rdata[ENTRY_W-1:0] = st.table_mem[idx_pair];
          end
        end
        OFS_GAMMA: begin
          next_st.rdata[GAMMA_W-1:0] = st.gamma;
        end
        OFS_STATUS: begin
          next_st.rdata[15:0] = st.pix_count;
          next_st.rdata[23:16] = st.last_pix;
        end
        OFS_IGNORE: begin
          next_st.rdata[15:0] = st.ignore_count;
        end
        default: begin
        end
      endcase
    end

    // ------------------------------------------------------------------------
    // Stage 1: fetch both even neighbours of the incoming sample
    in_pair = pix_in.data[9:1];
    next_st.s1_v = pix_in.valid;
    next_st.s1_raw = pix_in.data;
    next_st.s1_map = st.map_en;
    next_st.s1_lo = st.table_mem[in_pair];
    if (in_pair == TOP_PAIR) begin
      next_st.s1_hi = st.table_mem[in_pair];
    end else begin
      next_st.s1_hi = st.table_mem[9'(in_pair + 9'h001)];
    end

    // ------------------------------------------------------------------------
    // Stage 2: select raw, direct or interpolated value
    pair_sum = {1'h0, st.s1_lo} + {1'h0, st.s1_hi};
    next_st.s2_v = st.s1_v;
    if (!st.s1_map) begin
      next_st.s2_m10 = st.s1_raw;
    end else if (!st.s1_raw[0]) begin
      next_st.s2_m10 = st.s1_lo;
    end else if (st.s1_raw == TOP_CODE) begin
      next_st.s2_m10 = st.s1_lo;
    end else begin
      next_st.s2_m10 = pair_sum[10:1];
    end

    // ------------------------------------------------------------------------
    // Output bookkeeping
    if (gam_out.valid) begin
      next_st.pix_count = 16'(st.pix_count + 16'h0001);
      next_st.last_pix = gam_out.data;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= '0;
      st.gamma <= GAMMA_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Gamma stage after the mapping, in the selected output format
  always_comb begin
    gam_in.valid = st.s2_v;
    if (st.wide) begin
      gam_in.data = {st.s2_m10, st.s2_m10[9:8]};
    end else begin
      gam_in.data = {4'h0, st.s2_m10[9:2]};
    end
  end

  plg_gamma u_gamma (
    .clk      (clk),
    .reset    (reset),
    .gamma_en (st.gam_en),
    .wide     (st.wide),
    .factor   (st.gamma),
    .samp_in  (gam_in),
    .pix_out  (gam_out)
  );

  assign pix_out   = gam_out;
  assign reg_rdata = st.rdata;

endmodule : plg_top

// ==== bench/plg_checker.sv ====
`timescale 1ns/1ns
module plg_checker
  import plg_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              reset,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata,
  // Pixel stream
  input wire plg_pix_in_s       pix_in,
  input wire plg_pix_out_s      pix_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic idx_odd;
  logic mapped;
  assign mapped = reg_addr inside {OFS_CTRL, OFS_SELECT, OFS_INDEX, OFS_VALUE,
                                   OFS_GAMMA, OFS_STATUS, OFS_IGNORE};
  // Parity of the index last written
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      idx_odd <= 1'b0;
    end else if (reg_wr && reg_addr == OFS_INDEX) begin
      idx_odd <= reg_wdata[0];
    end
  end
  // ==========
  // Register port
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  unmapped_zero_a: assert property (reg_rd && !mapped |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  index_echo_a: assert property ((reg_wr && reg_addr == OFS_INDEX) ##1
    (reg_rd && reg_addr == OFS_INDEX) |=> reg_rdata == ($past(reg_wdata, 2) & 32'h3FF))
    else $error("index readback differs");
  odd_value_a: assert property (reg_rd && reg_addr == OFS_VALUE && idx_odd |=>
    reg_rdata == 32'h0)
    else $error("odd entry read not zero");
  gamma_width_a: assert property (reg_rd && reg_addr == OFS_GAMMA |=>
    reg_rdata[31:12] == 20'h0)
    else $error("gamma upper bits set");
  ctrl_width_a: assert property (reg_rd && reg_addr == OFS_CTRL |=>
    reg_rdata[31:3] == 29'h0)
    else $error("control upper bits set");
  // ==========
  // Pixel stream
  pix_latency_a: assert property (pix_in.valid |-> ##5 pix_out.valid)
    else $error("pixel not out after fixed latency");
  pix_gap_a: assert property (!pix_in.valid |-> ##5 !pix_out.valid)
    else $error("pixel out without input");
  pix_trunc_a: assert property (pix_out.valid |-> pix_out.data == pix_out.wide[11:4])
    else $error("narrow pixel not upper bits");
  px_run_c: cover property (pix_out.valid && $past(pix_out.valid));
  value_rd_c: cover property (reg_rd && reg_addr == OFS_VALUE);
  unmapped_c: cover property (reg_rd && !mapped);
endmodule : plg_checker

bind plg_top plg_checker i_chk (.clk(clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pix_in(pix_in), .pix_out(pix_out));

// ==== bench/plg_sensor_model.sv ====
`timescale 1ns/1ns
module plg_sensor_model
  import plg_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset,
  // Bench control
  input wire logic       go,
  input wire logic [9:0] sample,
  input wire logic       slow,
  // Samples toward the block
  output plg_pix_in_s    pix_in
);
  logic [9:0] q[$];
  logic       tick;
  // One 10-bit sample a cycle, or every other cycle when slow
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pix_in <= '0;
      tick   <= 1'b0;
      q.delete();
    end else begin
      if (go) begin
        q.push_back(sample);
      end
      tick <= ~tick;
      if (q.size() > 0 && !(slow && tick)) begin
        pix_in <= {1'b1, q.pop_front()};
      end else begin
        // Idle data toggles so stale values never look valid
        pix_in <= {1'b0, ~pix_in.data};
      end
    end
  end
endmodule : plg_sensor_model

// ==== bench/pixel_lut_gamma_map_test.sv ====
`timescale 1ns/1ns
module pixel_lut_gamma_map_test
  import plg_pkg::*;
;
  logic              clk       = 1'b0;
  logic              reset     = 1'b1;
  logic [ADDR_W-1:0] reg_addr  = 8'h00;
  logic [31:0]       reg_wdata = 32'h0;
  logic              reg_wr    = 1'b0;
  logic              reg_rd    = 1'b0;
  logic [31:0]       reg_rdata;
  logic              go        = 1'b0;
  logic              slow      = 1'b0;
  logic [9:0]        smp       = 10'h000;
  plg_pix_in_s       pix_in;
  plg_pix_out_s      pix_out;
  logic [7:0]        exp_q[$];
  logic [7:0]        last_px   = 8'h00;
  int                n_px      = 0;
  int                err_total = 0;
  int                compares  = 0;
  always #2 clk = ~clk;
  plg_top i_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pix_in(pix_in), .pix_out(pix_out));
  plg_sensor_model i_sensor (.clk(clk), .reset(reset), .go(go), .sample(smp), .slow(slow),
    .pix_in(pix_in));
  // ==========
  // Compare, bus and stream tasks
  task automatic chk_reg(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_reg
  // Wide field carries the 8-bit value with its upper nibble repeated
  task automatic chk_pix(input logic [7:0] exp, input plg_pix_out_s got);
    compares++;
    if (got.data !== exp || got.wide !== {exp, exp[7:4]}) begin
      err_total++;
      $display("[FAIL] pixel expected %h/%h seen %h/%h", exp, {exp, exp[7:4]},
               got.data, got.wide);
    end
  endtask : chk_pix
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    go        <= 1'b0;
    reg_rd    <= 1'b0;
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    go       <= 1'b0;
    reg_wr   <= 1'b0;
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk_reg($sformatf("reg %h", a), exp, reg_rdata);
  endtask : rd
  task automatic px(input logic [9:0] s, input logic [7:0] exp);
    @(posedge clk);
    reg_wr <= 1'b0;
    go     <= 1'b1;
    smp    <= s;
    exp_q.push_back(exp);
    last_px = exp;
    n_px++;
  endtask : px
  task automatic flush;
    @(posedge clk);
    go     <= 1'b0;
    reg_wr <= 1'b0;
    for (int i = 0; i < 100 && exp_q.size() > 0; i++) begin
      @(posedge clk);
    end
    chk_reg("pixels pending", 32'h0, 32'(exp_q.size()));
  endtask : flush
  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  always @(negedge clk) begin
    if (pix_out.valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("[FAIL] pixel expected none seen %h", pix_out.data);
      end else begin
        chk_pix(exp_q.pop_front(), pix_out);
      end
    end
  end
  initial begin
    #80000;
    err_total++;
    $display("[FAIL] watchdog expected done seen hang");
    finish_test();
  end
  // ==========
  // Tests
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rd(OFS_CTRL, 32'h0);
    rd(OFS_SELECT, 32'h0);
    rd(OFS_GAMMA, 32'h400);
    rd(OFS_STATUS, 32'h0);
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, 32'h0);
    $display("test reset_values done");
    px(10'h000, 8'h00);
    px(10'h003, 8'h00);
    px(10'h155, 8'h55);
    px(10'h3FF, 8'hFF);
    flush();
    $display("test raw_path done");
    wr(OFS_SELECT, 32'h0);
    for (int i = 0; i < 1024; i += 2) begin
      wr(OFS_INDEX, 32'(i));
      wr(OFS_VALUE, 32'(1023 - i));
    end
    wr(OFS_INDEX, 32'h8);
    wr(OFS_VALUE, 32'h7);
    wr(OFS_INDEX, 32'hA);
    wr(OFS_VALUE, 32'h0);
    wr(OFS_INDEX, 32'h3FE);
    wr(OFS_VALUE, 32'h3FC);
    wr(OFS_INDEX, 32'h5);
    rd(OFS_INDEX, 32'h5);
    wr(OFS_VALUE, 32'h0);
    rd(OFS_VALUE, 32'h0);
    wr(OFS_SELECT, 32'h1);
    wr(OFS_INDEX, 32'h4);
    wr(OFS_VALUE, 32'h0);
    rd(OFS_SELECT, 32'h1);
    wr(OFS_SELECT, 32'h0);
    rd(OFS_VALUE, 32'h3FB);
    rd(OFS_IGNORE, 32'h2);
    px(10'h004, 8'h01);
    flush();
    wr(OFS_CTRL, 32'h1);
    // End the write strobe after one cycle before the slow stream starts
    @(posedge clk);
    reg_wr <= 1'b0;
    slow   <= 1'b1;
    px(10'h000, 8'hFF);
    px(10'h004, 8'hFE);
    px(10'h005, 8'hFE);
    px(10'h009, 8'h00);
    px(10'h3FD, 8'h7F);
    px(10'h3FF, 8'hFF);
    px(10'h3FE, 8'hFF);
    flush();
    slow <= 1'b0;
    rd(OFS_STATUS, {8'h00, last_px, 16'(n_px)});
    $display("test table_map done");
    wr(OFS_CTRL, 32'h2);
    px(10'h155, 8'h55);
    flush();
    wr(OFS_GAMMA, 32'hFFF);
    px(10'h000, 8'h00);
    px(10'h3FF, 8'hFF);
    flush();
    // Factor 2.0 on 128 of 255 gives 64.25, floored to 64
    wr(OFS_GAMMA, 32'h800);
    px(10'h200, 8'h40);
    flush();
    wr(OFS_GAMMA, 32'h0);
    px(10'h100, 8'hFF);
    px(10'h001, 8'h00);
    flush();
    wr(OFS_CTRL, 32'h6);
    px(10'h001, 8'hFF);
    flush();
    wr(OFS_CTRL, 32'h0);
    px(10'h100, 8'h40);
    flush();
    rd(OFS_CTRL, 32'h0);
    $display("test gamma done");
    finish_test();
  end
endmodule : pixel_lut_gamma_map_test
